// *** inc/oic_cfg.svh ***
// constants of the two-wire display write link
`ifndef OIC_CFG_SVH
`define OIC_CFG_SVH
// target address and frame fields
`define OIC_ADDR_BASE 6'h1e
`define OIC_RW_WRITE 1'b0
`define OIC_BIT_LAST 4'h8
`define OIC_BIT_ZERO 4'h0
`define OIC_BIT_STEP 4'h1
`define OIC_CONT_BIT 7
`define OIC_DC_BIT 6
`define OIC_CMD_DISP_BIT 7
`define OIC_CMD_GLYPH_OP 2'h1
`define OIC_DISP_RST 7'h00
`define OIC_GLYPH_RST 6'h00
`define OIC_DISP_DEPTH 128
`define OIC_GLYPH_DEPTH 64
// synchroniser idle levels: strap low, sda and scl released
`define OIC_SYNC_RST 3'h3
`define OIC_PREV_RST 2'h3
// timing
`define OIC_CLK_NS 25
`define OIC_SCL_PERIOD_NS 2500
`define OIC_SCL_HALF_CYC ((`OIC_SCL_PERIOD_NS) / (2 * `OIC_CLK_NS))
// controller registers
`define OIC_REG_TX 8'h00
`define OIC_REG_ADDR 8'h04
`define OIC_REG_STATUS 8'h08
`define OIC_TX_LAST_BIT 8
`define OIC_ST_NACK_BIT 1
`define OIC_ADDR_RST 7'h3c
`define OIC_BIT_MSB 3'h7
`define OIC_IDX_STEP 3'h1
`endif

// *** inc/oic_pkg.sv ***
// state types of both link ends
package oic_pkg;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_RECV = 2'b01,
    T_ACK = 2'b11,
    T_SKIP = 2'b10
  } oic_tgt_state_t;
  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_CTRL = 2'b01,
    K_PAYLOAD = 2'b11
  } oic_kind_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_SHIFT = 3'b011,
    H_ACK = 3'b010,
    H_WAIT = 3'b110,
    H_STOP = 3'b111
  } oic_host_state_t;
endpackage : oic_pkg

// *** inc/oic_if.sv ***
// open-drain two-wire link between controller and display target
`timescale 1ns/10ps
interface oic_if;
  logic sclOut;
  logic sclOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = !(sclOe && !sclOut);
  assign sda = !(sdaHostOe && !sdaHostOut) && !(sdaDevOe && !sdaDevOut);
  modport host (output sclOut, output sclOe, output sdaHostOut, output sdaHostOe,
    input scl, input sda);
  modport dev (output sdaDevOut, output sdaDevOe, input scl, input sda);
endinterface : oic_if

// *** src/oic_sync.sv ***
// two-flop synchroniser for bus lines and strap, with previous levels
`timescale 1ns/10ps
`include "oic_cfg.svh"
module oic_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic strapIn,
  output logic sclSync,
  output logic sdaSync,
  output logic strapSync,
  output logic sclPrev,
  output logic sdaPrev
);
  logic [2:0] meta;
  logic [2:0] stable;
  logic [1:0] prev;
  logic [2:0] next_meta;
  logic [2:0] next_stable;
  logic [1:0] next_prev;

  always_comb begin
    next_meta = {strapIn, sdaIn, sclIn};
    next_stable = meta;
    next_prev = stable[1:0];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= `OIC_SYNC_RST;
      stable <= `OIC_SYNC_RST;
      prev <= `OIC_PREV_RST;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign sclSync = stable[0];
  assign sdaSync = stable[1];
  assign strapSync = stable[2];
  assign sclPrev = prev[0];
  assign sdaPrev = prev[1];
endmodule : oic_sync

// *** src/oic_host.sv ***
// two-wire controller end: register port in, write frames out
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "oic_cfg.svh"
module oic_host (
  input wire logic clk,
  input wire logic sys_rst,
  oic_if.host bus,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata
);
  import oic_pkg::*;
  localparam logic [6:0] HALF = 7'(`OIC_SCL_HALF_CYC - 1);

  logic sdaS;
  oic_host_state_t state, next_state;
  logic [1:0] sub, next_sub;
  logic [6:0] timer, next_timer;
  logic [7:0] shiftReg, next_shiftReg;
  logic [2:0] bitIdx, next_bitIdx;
  logic lastSent, next_lastSent;
  logic pendValid, next_pendValid;
  logic [7:0] pendByte, next_pendByte;
  logic pendLast, next_pendLast;
  logic [6:0] tgtAddr, next_tgtAddr;
  logic nack, next_nack;
  logic sclOe, next_sclOe;
  logic sdaOe, next_sdaOe;
  logic [31:0] rdata, next_rdata;
  logic timerDone;

  oic_sync uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclIn(bus.scl),
    .sdaIn(bus.sda),
    .strapIn(1'b0),
    .sclSync(),
    .sdaSync(sdaS),
    .strapSync(),
    .sclPrev(),
    .sdaPrev()
  );

  assign timerDone = (timer == 7'h00);

  always_comb begin
    next_state = state;
    next_sub = sub;
    next_timer = timerDone ? timer : timer - 7'h01;
    next_shiftReg = shiftReg;
    next_bitIdx = bitIdx;
    next_lastSent = lastSent;
    next_pendValid = pendValid;
    next_pendByte = pendByte;
    next_pendLast = pendLast;
    next_tgtAddr = tgtAddr;
    next_nack = nack;
    next_sclOe = sclOe;
    next_sdaOe = sdaOe;
    next_rdata = 32'h0;
    // -------------------------------------------------------------
    // register port
    // -------------------------------------------------------------
    if (regRead) begin
      if (regAddr == `OIC_REG_TX) begin
        next_rdata = {23'h0, pendLast, pendByte};
      end else if (regAddr == `OIC_REG_ADDR) begin
        next_rdata = {25'h0, tgtAddr};
      end else if (regAddr == `OIC_REG_STATUS) begin
        next_rdata = {29'h0, (state != H_IDLE), nack, !pendValid};
      end
    end
    if (regWrite) begin
      if (regAddr == `OIC_REG_TX) begin
        if (!pendValid) begin
          next_pendValid = 1'b1;
          next_pendByte = regWdata[7:0];
          next_pendLast = regWdata[`OIC_TX_LAST_BIT];
        end
      end else if (regAddr == `OIC_REG_ADDR) begin
        if (state == H_IDLE) begin
          next_tgtAddr = regWdata[6:0];
        end
      end else if (regAddr == `OIC_REG_STATUS) begin
        if (regWdata[`OIC_ST_NACK_BIT]) begin
          next_nack = 1'b0;
        end
      end
    end
    // -------------------------------------------------------------
    // frame sequencer
    // -------------------------------------------------------------
    case (state)
      H_IDLE: begin
        if (pendValid) begin
          next_sdaOe = 1'b1;
          next_timer = HALF;
          next_state = H_START;
        end
      end
      H_START: begin
        if (timerDone) begin
          next_sclOe = 1'b1;
          next_shiftReg = {tgtAddr, `OIC_RW_WRITE};
          next_bitIdx = `OIC_BIT_MSB;
          next_lastSent = 1'b0;
          next_sub = 2'h0;
          next_timer = HALF;
          next_state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (sub == 2'h0) begin
          next_sdaOe = !shiftReg[bitIdx];
          if (timerDone) begin
            next_sclOe = 1'b0;
            next_sub = 2'h1;
            next_timer = HALF;
          end
        end else if (timerDone) begin
          next_sclOe = 1'b1;
          next_sub = 2'h0;
          next_timer = HALF;
          if (bitIdx == 3'h0) begin
            next_state = H_ACK;
          end else begin
            next_bitIdx = bitIdx - `OIC_IDX_STEP;
          end
        end
      end
      H_ACK: begin
        if (sub == 2'h0) begin
          next_sdaOe = 1'b0;
          if (timerDone) begin
            next_sclOe = 1'b0;
            next_sub = 2'h1;
            next_timer = HALF;
          end
        end else if (timerDone) begin
          next_sclOe = 1'b1;
          next_sub = 2'h0;
          next_timer = HALF;
          if (sdaS) begin
            next_nack = 1'b1;
            next_pendValid = 1'b0;
            next_state = H_STOP;
          end else if (lastSent) begin
            next_state = H_STOP;
          end else begin
            next_state = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        if (pendValid) begin
          next_shiftReg = pendByte;
          next_lastSent = pendLast;
          next_pendValid = 1'b0;
          next_bitIdx = `OIC_BIT_MSB;
          next_sub = 2'h0;
          next_timer = HALF;
          next_state = H_SHIFT;
        end
      end
      H_STOP: begin
        if (sub == 2'h0) begin
          next_sdaOe = 1'b1;
          if (timerDone) begin
            next_sclOe = 1'b0;
            next_sub = 2'h1;
            next_timer = HALF;
          end
        end else if (sub == 2'h1) begin
          if (timerDone) begin
            next_sdaOe = 1'b0;
            next_sub = 2'h2;
            next_timer = HALF;
          end
        end else if (timerDone) begin
          next_sub = 2'h0;
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= H_IDLE;
      sub <= 2'h0;
      timer <= 7'h00;
      shiftReg <= 8'h00;
      bitIdx <= 3'h0;
      lastSent <= 1'b0;
      pendValid <= 1'b0;
      pendByte <= 8'h00;
      pendLast <= 1'b0;
      tgtAddr <= `OIC_ADDR_RST;
      nack <= 1'b0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      rdata <= 32'h0;
    end else begin
      state <= next_state;
      sub <= next_sub;
      timer <= next_timer;
      shiftReg <= next_shiftReg;
      bitIdx <= next_bitIdx;
      lastSent <= next_lastSent;
      pendValid <= next_pendValid;
      pendByte <= next_pendByte;
      pendLast <= next_pendLast;
      tgtAddr <= next_tgtAddr;
      nack <= next_nack;
      sclOe <= next_sclOe;
      sdaOe <= next_sdaOe;
      rdata <= next_rdata;
    end
  end

  assign bus.sclOut = 1'b0;
  assign bus.sdaHostOut = 1'b0;
  assign bus.sclOe = sclOe;
  assign bus.sdaHostOe = sdaOe;
  assign regRdata = rdata;
endmodule : oic_host

// *** src/oic_target.sv ***
// two-wire display target: frame decode, command and character RAM writes
// Operation
// - falling data while clock high starts frame
// - answer address 0111100 or 0111101 per strap
// - direction bit zero means write mode
// - pull data low through ninth clock high
// - control byte: continuation, select, six zeros
// - continuation zero: rest of frame is payload
// - select zero command, one character RAM data
// - advance RAM address after each data write
// - acknowledge every control and payload byte
// - rising data while clock high stops frame
// - data changes only while clock low
// - route data to RAMs, commands to register
`timescale 1ns/10ps
`include "oic_cfg.svh"
module oic_target (
  input wire logic clk,
  input wire logic sys_rst,
  oic_if.dev bus,
  input wire logic addrLsbStrap,
  input wire logic [6:0] dispRdAddr,
  input wire logic [5:0] glyphRdAddr,
  output logic cmdWrite,
  output logic [7:0] cmdByte,
  output logic ramWrite,
  output logic ramGlyph,
  output logic [6:0] ramAddr,
  output logic [7:0] ramData,
  output logic [6:0] addrCounter,
  output logic [7:0] dispRdData,
  output logic [7:0] glyphRdData
);
  import oic_pkg::*;

  logic sclS, sdaS, strapS, sclP, sdaP;
  logic startCond, stopCond, sclRise, sclFall;
  oic_tgt_state_t state, next_state;
  oic_kind_t kind, next_kind;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shiftReg, next_shiftReg;
  logic streamOnly, next_streamOnly;
  logic dcSel, next_dcSel;
  logic glyphSel, next_glyphSel;
  logic [6:0] dispAddr, next_dispAddr;
  logic [5:0] glyphAddr, next_glyphAddr;
  logic sdaOe, next_sdaOe;
  logic next_cmdWrite;
  logic [7:0] next_cmdByte;
  logic next_ramWrite;
  logic next_ramGlyph;
  logic [6:0] next_ramAddr;
  logic [7:0] next_ramData;
  logic [7:0] next_dispRdData;
  logic [7:0] next_glyphRdData;
  logic [7:0] dispMem [`OIC_DISP_DEPTH];
  logic [7:0] glyphMem [`OIC_GLYPH_DEPTH];

  oic_sync uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclIn(bus.scl),
    .sdaIn(bus.sda),
    .strapIn(addrLsbStrap),
    .sclSync(sclS),
    .sdaSync(sdaS),
    .strapSync(strapS),
    .sclPrev(sclP),
    .sdaPrev(sdaP)
  );

  // -------------------------------------------------------------
  // line events
  // -------------------------------------------------------------
  assign startCond = sclS && sclP && sdaP && !sdaS;
  assign stopCond = sclS && sclP && !sdaP && sdaS;
  assign sclRise = sclS && !sclP;
  assign sclFall = !sclS && sclP;

  // -------------------------------------------------------------
  // frame decoder
  // -------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_bitCnt = bitCnt;
    next_shiftReg = shiftReg;
    next_streamOnly = streamOnly;
    next_dcSel = dcSel;
    next_glyphSel = glyphSel;
    next_dispAddr = dispAddr;
    next_glyphAddr = glyphAddr;
    next_sdaOe = sdaOe;
    next_cmdWrite = 1'b0;
    next_cmdByte = cmdByte;
    next_ramWrite = 1'b0;
    next_ramGlyph = ramGlyph;
    next_ramAddr = ramAddr;
    next_ramData = ramData;
    next_dispRdData = dispMem[dispRdAddr];
    next_glyphRdData = glyphMem[glyphRdAddr];
    if (stopCond) begin
      next_state = T_IDLE;
      next_sdaOe = 1'b0;
    end else if (startCond) begin
      next_state = T_RECV;
      next_kind = K_ADDR;
      next_bitCnt = `OIC_BIT_ZERO;
      next_sdaOe = 1'b0;
    end else begin
      case (state)
        T_RECV: begin
          if (sclRise) begin
            next_shiftReg = {shiftReg[6:0], sdaS};
            next_bitCnt = bitCnt + `OIC_BIT_STEP;
          end else if (sclFall && bitCnt == `OIC_BIT_LAST) begin
            next_state = T_ACK;
            next_sdaOe = 1'b1;
            case (kind)
              K_ADDR: begin
                if (shiftReg[7:1] == {`OIC_ADDR_BASE, strapS} &&
                    shiftReg[0] == `OIC_RW_WRITE) begin
                  next_kind = K_CTRL;
                end else begin
                  next_state = T_SKIP;
                  next_sdaOe = 1'b0;
                end
              end
              K_CTRL: begin
                // low six bits are zero by the sender and not looked at
                next_streamOnly = !shiftReg[`OIC_CONT_BIT];
                next_dcSel = shiftReg[`OIC_DC_BIT];
                next_kind = K_PAYLOAD;
              end
              default: begin
                next_kind = streamOnly ? K_PAYLOAD : K_CTRL;
                if (dcSel) begin
                  next_ramWrite = 1'b1;
                  next_ramGlyph = glyphSel;
                  next_ramData = shiftReg;
                  if (glyphSel) begin
                    next_ramAddr = {1'b0, glyphAddr};
                    next_glyphAddr = glyphAddr + 6'h01;
                  end else begin
                    next_ramAddr = dispAddr;
                    next_dispAddr = dispAddr + 7'h01;
                  end
                end else begin
                  next_cmdWrite = 1'b1;
                  next_cmdByte = shiftReg;
                  if (shiftReg[`OIC_CMD_DISP_BIT]) begin
                    next_dispAddr = shiftReg[6:0];
                    next_glyphSel = 1'b0;
                  end else if (shiftReg[7:6] == `OIC_CMD_GLYPH_OP) begin
                    next_glyphAddr = shiftReg[5:0];
                    next_glyphSel = 1'b1;
                  end
                end
              end
            endcase
          end
        end
        T_ACK: begin
          if (sclFall) begin
            next_sdaOe = 1'b0;
            next_bitCnt = `OIC_BIT_ZERO;
            next_state = T_RECV;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= T_IDLE;
      kind <= K_ADDR;
      bitCnt <= `OIC_BIT_ZERO;
      shiftReg <= 8'h00;
      streamOnly <= 1'b0;
      dcSel <= 1'b0;
      glyphSel <= 1'b0;
      dispAddr <= `OIC_DISP_RST;
      glyphAddr <= `OIC_GLYPH_RST;
      sdaOe <= 1'b0;
      cmdWrite <= 1'b0;
      cmdByte <= 8'h00;
      ramWrite <= 1'b0;
      ramGlyph <= 1'b0;
      ramAddr <= 7'h00;
      ramData <= 8'h00;
      dispRdData <= 8'h00;
      glyphRdData <= 8'h00;
    end else begin
      state <= next_state;
      kind <= next_kind;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      streamOnly <= next_streamOnly;
      dcSel <= next_dcSel;
      glyphSel <= next_glyphSel;
      dispAddr <= next_dispAddr;
      glyphAddr <= next_glyphAddr;
      sdaOe <= next_sdaOe;
      cmdWrite <= next_cmdWrite;
      cmdByte <= next_cmdByte;
      ramWrite <= next_ramWrite;
      ramGlyph <= next_ramGlyph;
      ramAddr <= next_ramAddr;
      ramData <= next_ramData;
      dispRdData <= next_dispRdData;
      glyphRdData <= next_glyphRdData;
    end
  end

  // -------------------------------------------------------------
  // character storage
  // -------------------------------------------------------------
  for (genvar g = 0; g < `OIC_DISP_DEPTH; g++) begin : gDisp
    always_ff @(posedge clk) begin
      if (ramWrite && !ramGlyph && ramAddr == 7'(g)) begin
        dispMem[g] <= ramData;
      end
    end
  end
  for (genvar g = 0; g < `OIC_GLYPH_DEPTH; g++) begin : gGlyph
    always_ff @(posedge clk) begin
      if (ramWrite && ramGlyph && ramAddr == 7'(g)) begin
        glyphMem[g] <= ramData;
      end
    end
  end

  assign addrCounter = dispAddr;
  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOe = sdaOe;
endmodule : oic_target

// *** verification/oic_link_checker.sv ***
// concurrent checks on the link between controller and display target
`timescale 1ns/10ps
module oic_link_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sdaHostOe,
  input wire logic sdaDevOe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------
  // frame and bit tracking
  // ----------------------------
  typedef struct packed {
    logic sclQ;
    logic sdaQ;
    logic [3:0] cnt;
    logic [7:0] shReg;
    logic firstByte;
    logic frameAck;
    logic inFrame;
    logic [6:0] highCnt;
  } oic_trk_t;
  oic_trk_t trk;
  oic_trk_t next_trk;
  logic start;
  logic stop;
  logic rise;
  assign start = scl && trk.sclQ && trk.sdaQ && !sda;
  assign stop = scl && trk.sclQ && !trk.sdaQ && sda;
  assign rise = scl && !trk.sclQ;
  always_comb begin
    next_trk = trk;
    next_trk.sclQ = scl;
    next_trk.sdaQ = sda;
    // high time restarts on any data change so start counts from the edge
    next_trk.highCnt = (!scl || sda != trk.sdaQ) ? 7'h00 : trk.highCnt + 7'h01;
    if (start) begin
      next_trk.cnt = 4'h0;
      next_trk.firstByte = 1'b1;
      next_trk.frameAck = 1'b0;
      next_trk.inFrame = 1'b1;
    end else if (stop) begin
      next_trk.inFrame = 1'b0;
    end else if (rise) begin
      next_trk.cnt = (trk.cnt == 4'h9) ? 4'h1 : trk.cnt + 4'h1;
      if (trk.cnt != 4'h8) begin
        next_trk.shReg = {trk.shReg[6:0], sda};
      end else if (trk.firstByte) begin
        next_trk.firstByte = 1'b0;
        next_trk.frameAck = sdaDevOe;
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trk <= {2'b11, 22'h000000};
    end else begin
      trk <= next_trk;
    end
  end
  // ----------------------------
  // link properties
  // ----------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  start_clock_a: assert property (start |-> scl [*8] ##[30:52] !scl)
    else $error("no clock pulse after start");
  addr_ack_a: assert property (
    rise && trk.cnt == 4'h8 && trk.firstByte && sdaDevOe |-> trk.shReg inside {8'h78, 8'h7a})
    else $error("ack for a foreign address or a read");
  ack_hold_a: assert property (
    scl && trk.sclQ && trk.cnt == 4'h9 |-> $stable(sdaDevOe))
    else $error("target ack changed during clock high");
  dev_quiet_a: assert property (
    scl && trk.sclQ && trk.cnt != 4'h9 |-> !sdaDevOe)
    else $error("target pulled data outside ack bit");
  host_release_a: assert property (
    scl && trk.sclQ && trk.cnt == 4'h9 |-> !sdaHostOe)
    else $error("controller held data during ack bit");
  byte_ack_a: assert property (
    rise && trk.cnt == 4'h8 && !trk.firstByte && trk.inFrame |-> sdaDevOe == trk.frameAck)
    else $error("byte ack differs from address ack");
  bit_stable_a: assert property (rise |-> $stable(sda) [*8])
    else $error("data moved after clock rise");
  high_time_a: assert property (
    $fell(scl) |-> trk.highCnt >= 7'h30 && trk.highCnt <= 7'h33)
    else $error("clock high time off");
  stop_idle_a: assert property (stop |-> (scl && sda) [*8])
    else $error("lines not idle after stop");
  idle_quiet_a: assert property (!trk.inFrame |-> !sdaDevOe)
    else $error("target pulled data outside a frame");
endmodule : oic_link_checker

// *** verification/testbench.sv ***
// self-checking bench of the two-wire display write link, both ends
`timescale 1ns/10ps
`include "oic_cfg.svh"
module testbench;
  logic clk;
  logic sys_rst;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  logic addrLsbStrap;
  logic [6:0] dispRdAddr;
  logic [5:0] glyphRdAddr;
  logic cmdWrite;
  logic [7:0] cmdByte;
  logic ramWrite;
  logic ramGlyph;
  logic [6:0] ramAddr;
  logic [7:0] ramData;
  logic [6:0] addrCounter;
  logic [7:0] dispRdData;
  logic [7:0] glyphRdData;
  logic [15:0] ramQ[$];
  logic [7:0] cmdQ[$];
  logic [7:0] txQ[$];
  logic [31:0] st;
  logic [7:0] dd;
  logic [7:0] gd;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  oic_if link();
  oic_host i_oic_host (.clk(clk), .sys_rst(sys_rst), .bus(link), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  oic_target i_oic_target (.clk(clk), .sys_rst(sys_rst), .bus(link),
    .addrLsbStrap(addrLsbStrap), .dispRdAddr(dispRdAddr), .glyphRdAddr(glyphRdAddr),
    .cmdWrite(cmdWrite), .cmdByte(cmdByte), .ramWrite(ramWrite), .ramGlyph(ramGlyph),
    .ramAddr(ramAddr), .ramData(ramData), .addrCounter(addrCounter),
    .dispRdData(dispRdData), .glyphRdData(glyphRdData));
  oic_link_checker i_oic_link_checker (.clk(clk), .sys_rst(sys_rst),
    .sdaHostOe(link.sdaHostOe), .sdaDevOe(link.sdaDevOe), .scl(link.scl), .sda(link.sda));
  // ----------------------------
  // clock, timeout, monitors
  // ----------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      $display("ERROR %0t: run timed out", $time);
      results();
    end
  end
  always @(posedge clk) begin
    if (ramWrite === 1'b1) ramQ.push_back({ramGlyph, ramAddr, ramData});
    if (cmdWrite === 1'b1) cmdQ.push_back(cmdByte);
  end
  // ----------------------------
  // shared tasks
  // ----------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : regWr
  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : regRd
  task automatic ramRd(input logic [6:0] a);
    @(posedge clk);
    dispRdAddr <= a;
    glyphRdAddr <= a[5:0];
    repeat (2) @(posedge clk);
    #1 dd = dispRdData;
    gd = glyphRdData;
  endtask : ramRd
  task automatic waitStatus(input int idx, input logic val);
    int n;
    n = 0;
    do begin
      regRd(`OIC_REG_STATUS, st);
      n++;
    end while (st[idx] !== val && n < 3000);
    if (n == 3000) begin
      fail_count++;
      $display("ERROR %0t: status wait timed out", $time);
      results();
    end
  endtask : waitStatus
  // sends txQ as one frame, last byte closes it with a stop
  task automatic runFrame(input logic [6:0] a);
    regWr(`OIC_REG_ADDR, {25'h0, a});
    foreach (txQ[i]) begin
      waitStatus(0, 1'b1);
      regWr(`OIC_REG_TX, {23'h0, (i == txQ.size() - 1), txQ[i]});
    end
    waitStatus(2, 1'b0);
    txQ.delete();
    regRd(`OIC_REG_STATUS, st);
  endtask : runFrame
  // ----------------------------
  // scenarios
  // ----------------------------
  task automatic sIdle();
    regRd(`OIC_REG_STATUS, st);
    check(st, 32'h1);
    regRd(8'h0c, st);
    check(st, 32'h0);
    regRd(`OIC_REG_ADDR, st);
    check(st, {25'h0, `OIC_ADDR_RST});
    check(addrCounter, 32'h0);
  endtask : sIdle
  task automatic sData();
    txQ = {8'h40, 8'h41, 8'h42};
    runFrame(7'h3c);
    check(st, 32'h1);
    check(ramQ.size(), 32'h2);
    check(ramQ[0], 32'h0041);
    check(ramQ[1], 32'h0142);
    check(addrCounter, 32'h2);
    check(cmdQ.size(), 32'h0);
    ramRd(7'h01);
    check(dd, 32'h42);
  endtask : sData
  task automatic sAlt();
    ramQ.delete();
    txQ = {8'h80, 8'h85, 8'hc0, 8'h55, 8'h00, 8'h4a, 8'h81};
    runFrame(7'h3c);
    check(cmdQ.size(), 32'h3);
    check({cmdQ[0], cmdQ[1], cmdQ[2]}, 32'h854a81);
    check(ramQ.size(), 32'h1);
    check(ramQ[0], 32'h0555);
    check(addrCounter, 32'h1);
  endtask : sAlt
  task automatic sGlyph();
    ramQ.delete();
    txQ = {8'h80, 8'h4a, 8'h40, 8'h99, 8'h9a};
    runFrame(7'h3c);
    check({ramQ[0][15], ramQ[0][7:0]}, 32'h199);
    ramRd(7'h0a);
    check(gd, 32'h99);
    ramRd(7'h0b);
    check(gd, 32'h9a);
  endtask : sGlyph
  task automatic sStrap();
    ramQ.delete();
    cmdQ.delete();
    @(posedge clk);
    addrLsbStrap <= 1'b1;
    repeat (4) @(posedge clk);
    txQ = {8'h80, 8'h83, 8'h40, 8'h77};
    runFrame(7'h3d);
    check(st, 32'h1);
    check(ramQ[0], 32'h0377);
    check(addrCounter, 32'h4);
    ramQ.delete();
    cmdQ.delete();
    txQ = {8'h40};
    runFrame(7'h3c);
    check(st, 32'h3);
    check(ramQ.size() + cmdQ.size(), 32'h0);
    regWr(`OIC_REG_STATUS, 32'h2);
    regRd(`OIC_REG_STATUS, st);
    check(st, 32'h1);
  endtask : sStrap
  task automatic results();
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  initial begin
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    addrLsbStrap = 1'b0;
    dispRdAddr = 7'h00;
    glyphRdAddr = 6'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    sIdle();
    sData();
    sAlt();
    sGlyph();
    sStrap();
    results();
  end
endmodule : testbench
